// ===== include/wtu_pkg.sv
// constants shared by the watchdog timeout unit
package wtu_pkg;
	// bus geometry
	localparam int          ADR_W        = 4;
	localparam int          DAT_W        = 32;
	// register byte offsets
	localparam logic [3:0]  OFS_CTRL     = 4'h0;
	localparam logic [3:0]  OFS_IRQ_STAT = 4'h4;
	localparam logic [3:0]  OFS_IRQ_CLR  = 4'h8;
	localparam logic [3:0]  OFS_IRQ_EN   = 4'hc;
	// watchdog_control field positions
	localparam int          B_PRE_HI     = 7;
	localparam int          B_PRE_LO     = 4;
	localparam int          B_IRQ_RESP   = 3;
	localparam int          B_FLAG       = 2;
	localparam int          B_ARM        = 1;
	localparam int          B_UNLOCK     = 0;
	localparam logic [7:0]  CTRL_RST     = 8'h10;
	// prescale codes
	localparam logic [3:0]  PRE_MAX_TIMED = 4'h7;
	localparam logic [3:0]  PRE_IMMEDIATE = 4'h8;
	// base interval is 2^9 crystal ticks, counter is 16 bits
	localparam int          BASE_LOG2    = 9;
	localparam int          CNT_W        = 16;
	// interrupt status bits
	localparam int          IRQ_W        = 2;
	localparam int          IB_TIMEOUT   = 0;
	localparam int          IB_REJECT    = 1;
	localparam logic [1:0]  IRQ_RST      = 2'h0;
	// synchroniser depth for the crystal pin
	localparam int          SYNC_STAGES  = 3;
endpackage

// ===== rtl/wtu_xtal_sync.sv
// crystal pin synchroniser and rising edge detector
`timescale 1ns/1ps
module wtu_xtal_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// crystal pin
	input  wire logic xtal_in,
	// one-cycle pulse per crystal rising edge
	output logic      xtal_rise
);
	logic [wtu_pkg::SYNC_STAGES-1:0] stage;
	logic                            level;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= 3'h0;
		end else begin
			stage <= {stage[1:0], xtal_in};
		end
	end

	// stage[0] feeds only stage[1]; a change counts once stages 1 and 2 agree
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			level     <= 1'b0;
			xtal_rise <= 1'b0;
		end else begin
			xtal_rise <= 1'b0;
			if (stage[1] == stage[2]) begin
				level     <= stage[2];
				xtal_rise <= stage[2] & ~level;
			end
		end
	end
endmodule // wtu_xtal_sync

// ===== rtl/wtu_watchdog.sv
// watchdog timeout unit with wishbone register access
// Functional notes
// - prescale code 0..7 gives 15.6 ms doubling to 2000 ms; 8 resets at once
// - response bit 1 raises watchdog interrupt on timeout, 0 resets the system
// - watchdog interrupt bypasses global disable and has fixed high priority
// - every timeout sets the status flag, whichever response is chosen
// - status flag clears only by software writing 0 or external reset
// - writing arm bit 1 enables the watchdog and restarts the counter
// - software re-arms within each period, else reset or interrupt follows
// - arm clears on write 0, watchdog reset, hardware reset, supply interrupt
// - 16-bit counter advances on the 32.768 kHz crystal, not core clock
`timescale 1ns/1ps
module wtu_watchdog (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// crystal pin and supply monitor
	input  wire logic        xtal_in,
	input  wire logic        supply_monitor_int,
	// responses
	output logic             sys_reset_req,
	output logic             wdt_int_req,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////////
	// timeout limit: 2^(pre+9) ticks, minus one for the terminal count
	function automatic logic [15:0] limit_of(input logic [3:0] code);
		logic [16:0] span;
		// five-bit shift amount: code 7 needs a shift of 16
		span = 17'h00001 << (5'(code[2:0]) + 5'(wtu_pkg::BASE_LOG2));
		return 16'(span - 17'h00001);
	endfunction

	logic [3:0]  pre;
	logic        irq_resp;
	logic        timeout_status_flag;
	logic        watchdog_arm;
	logic        control_write_unlock;
	logic [15:0] cnt;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_en;
	logic        xtal_rise;

	wtu_xtal_sync u_sync (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.xtal_in   (xtal_in),
		.xtal_rise (xtal_rise)
	);

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	logic acc;
	logic wr;
	logic ctrl_hit;
	logic unlock_req;
	logic ctrl_wr;
	logic bad_wr;

	assign acc        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr         = acc & wb_we_i & wb_sel_i[0];
	assign ctrl_hit   = (wb_adr_i == wtu_pkg::OFS_CTRL);
	assign unlock_req = wr & ctrl_hit & ~control_write_unlock & wb_dat_i[wtu_pkg::B_UNLOCK];
	assign ctrl_wr    = wr & ctrl_hit & control_write_unlock;
	assign bad_wr     = wr & ctrl_hit & ~control_write_unlock & ~wb_dat_i[wtu_pkg::B_UNLOCK];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= acc;
		end
	end

	// any completed access consumes the unlock, so only the very next one counts
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			control_write_unlock <= 1'b0;
		end else if (acc) begin
			control_write_unlock <= unlock_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// timeout detection
	logic        timed_code;
	logic        immediate;
	logic        rearm;
	logic        at_limit;
	logic        timeout_evt;
	logic        reset_resp;

	assign timed_code  = (pre <= wtu_pkg::PRE_MAX_TIMED);
	assign immediate   = (pre == wtu_pkg::PRE_IMMEDIATE);
	assign rearm       = ctrl_wr & wb_dat_i[wtu_pkg::B_ARM];
	assign at_limit    = (cnt == limit_of(pre));
	// reserved codes above 8 never time out
	assign timeout_evt = watchdog_arm & ~rearm
		& (immediate | (timed_code & xtal_rise & at_limit));
	// the immediate code always resets, whatever the response bit says
	assign reset_resp  = immediate | ~irq_resp;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 16'h0000;
		end else if (rearm | ~watchdog_arm) begin
			cnt <= 16'h0000;
		end else if (xtal_rise & timed_code) begin
			cnt <= at_limit ? 16'h0000 : cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control register fields
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre      <= wtu_pkg::CTRL_RST[wtu_pkg::B_PRE_HI:wtu_pkg::B_PRE_LO];
			irq_resp <= wtu_pkg::CTRL_RST[wtu_pkg::B_IRQ_RESP];
		end else if (ctrl_wr) begin
			pre      <= wb_dat_i[wtu_pkg::B_PRE_HI:wtu_pkg::B_PRE_LO];
			irq_resp <= wb_dat_i[wtu_pkg::B_IRQ_RESP];
		end
	end

	// clears win over a write here: a supply fault must not leave it armed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_arm <= wtu_pkg::CTRL_RST[wtu_pkg::B_ARM];
		end else if (supply_monitor_int | (timeout_evt & reset_resp)) begin
			watchdog_arm <= 1'b0;
		end else if (ctrl_wr) begin
			watchdog_arm <= wb_dat_i[wtu_pkg::B_ARM];
		end
	end

	// only reset_n clears it by hardware; the watchdog reset is a request out
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			timeout_status_flag <= wtu_pkg::CTRL_RST[wtu_pkg::B_FLAG];
		end else if (timeout_evt) begin
			timeout_status_flag <= 1'b1;
		end else if (ctrl_wr & ~wb_dat_i[wtu_pkg::B_FLAG]) begin
			timeout_status_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// responses
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_reset_req <= 1'b0;
		end else begin
			sys_reset_req <= timeout_evt & reset_resp;
		end
	end

	// separate line to the core, outside the maskable interrupt path
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_int_req <= 1'b0;
		end else if (timeout_evt & ~reset_resp) begin
			wdt_int_req <= 1'b1;
		end else if (ctrl_wr & ~wb_dat_i[wtu_pkg::B_FLAG]) begin
			wdt_int_req <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event status, clear and enable
	logic       clr_wr;
	logic       en_wr;
	logic [1:0] events;

	assign clr_wr = wr & (wb_adr_i == wtu_pkg::OFS_IRQ_CLR);
	assign en_wr  = wr & (wb_adr_i == wtu_pkg::OFS_IRQ_EN);
	assign events = {bad_wr, timeout_evt};

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat <= wtu_pkg::IRQ_RST;
		end else begin
			irq_stat <= (irq_stat & ~({2{clr_wr}} & wb_dat_i[1:0])) | events;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en <= wtu_pkg::IRQ_RST;
		end else if (en_wr) begin
			irq_en <= wb_dat_i[1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, unmapped offsets read zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= 32'h00000000;
		end else if (acc & ~wb_we_i) begin
			case (wb_adr_i)
				wtu_pkg::OFS_CTRL: begin
					wb_dat_o <= {24'h000000, pre, irq_resp, timeout_status_flag,
						watchdog_arm, control_write_unlock};
				end
				wtu_pkg::OFS_IRQ_STAT: begin
					wb_dat_o <= {30'h0, irq_stat};
				end
				wtu_pkg::OFS_IRQ_EN: begin
					wb_dat_o <= {30'h0, irq_en};
				end
				default: begin
					wb_dat_o <= 32'h00000000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_immediate;
		watchdog_arm && immediate && !rearm |=> sys_reset_req && !watchdog_arm;
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("immediate code did not reset");

	property p_reset_mode;
		timeout_evt && !irq_resp |=> sys_reset_req && !$rose(wdt_int_req);
	endproperty
	a_reset_mode: assert property (p_reset_mode)
		else $error("reset response missing");

	property p_irq_mode;
		timeout_evt && irq_resp && timed_code && !supply_monitor_int
			|=> wdt_int_req && !sys_reset_req
			&& watchdog_arm;
	endproperty
	a_irq_mode: assert property (p_irq_mode)
		else $error("interrupt response missing");

	property p_flag_set;
		timeout_evt |=> timeout_status_flag && irq_stat[wtu_pkg::IB_TIMEOUT];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("status flag not set on timeout");

	property p_flag_hold;
		timeout_status_flag && !(ctrl_wr && !wb_dat_i[wtu_pkg::B_FLAG])
			|=> timeout_status_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("status flag lost without software clear");

	property p_rearm;
		rearm && !supply_monitor_int |=> cnt == 16'h0000 && watchdog_arm ##1 cnt <= 16'h0001;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("arm write did not restart counter");

	property p_supply;
		supply_monitor_int |=> !watchdog_arm;
	endproperty
	a_supply: assert property (p_supply)
		else $error("supply interrupt left watchdog armed");

	property p_bound;
		watchdog_arm && timed_code |-> cnt <= limit_of(pre);
	endproperty
	a_bound: assert property (p_bound)
		else $error("counter passed its limit");

	property p_no_tick_no_count;
		!xtal_rise && !rearm && watchdog_arm |=> $stable(cnt);
	endproperty
	a_no_tick_no_count: assert property (p_no_tick_no_count)
		else $error("counter moved without crystal tick");

	property p_locked;
		wr && ctrl_hit && !control_write_unlock |=> $stable(pre) && $stable(irq_resp);
	endproperty
	a_locked: assert property (p_locked)
		else $error("locked control write took effect");

	property p_unlock_once;
		acc && control_write_unlock |=> !control_write_unlock;
	endproperty
	a_unlock_once: assert property (p_unlock_once)
		else $error("unlock survived an access");

	property p_unlock_set;
		unlock_req |=> control_write_unlock;
	endproperty
	a_unlock_set: assert property (p_unlock_set)
		else $error("unlock request not held for next access");

	property p_reserved;
		watchdog_arm && !timed_code && !immediate |=> !sys_reset_req && !$rose(wdt_int_req);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved prescale code timed out");

	property p_idle_quiet;
		!watchdog_arm |=> !sys_reset_req && !$rose(wdt_int_req);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("disarmed watchdog responded");

	property p_disarm;
		ctrl_wr && !wb_dat_i[wtu_pkg::B_ARM] |=> !watchdog_arm;
	endproperty
	a_disarm: assert property (p_disarm)
		else $error("arm write of zero left watchdog armed");

	property p_reset_disarm;
		sys_reset_req |-> !watchdog_arm && timeout_status_flag;
	endproperty
	a_reset_disarm: assert property (p_reset_disarm)
		else $error("watchdog reset left arm set or flag clear");

	property p_count_step;
		xtal_rise && watchdog_arm && timed_code && !rearm && !at_limit
			|=> cnt == $past(cnt) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step on crystal tick");

	property p_int_hold;
		wdt_int_req && !(ctrl_wr && !wb_dat_i[wtu_pkg::B_FLAG]) |=> wdt_int_req;
	endproperty
	a_int_hold: assert property (p_int_hold)
		else $error("watchdog interrupt dropped without flag clear");
endmodule // wtu_watchdog

// ===== tb/test_watchdog_timeout_unit.sv
// self-checking bench for the watchdog timeout unit over wishbone
`timescale 1ns/1ps
module test_watchdog_timeout_unit;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, xtal = 1'b0, smi = 1'b0;
	logic [3:0]  sel = 4'h0, adr = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic        ack, rst_req, wint, irq;
	int          error_cnt = 0, checks_done = 0, rst_cnt = 0, cycles = 0, xdiv = 0;
	logic [7:0]  q;
	int          n;

	wtu_watchdog dut (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
		.wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.xtal_in(xtal), .supply_monitor_int(smi),
		.sys_reset_req(rst_req), .wdt_int_req(wint), .irq(irq)
	);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// fast crystal: one rising edge every 10 system cycles keeps timeouts short
	always @(posedge sys_clk) begin
		xdiv <= (xdiv == 4) ? 0 : xdiv + 1;
		if (xdiv == 4)
			xtal <= ~xtal;
		if (rst_req === 1'b1)
			rst_cnt <= rst_cnt + 1;
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one classic cycle; starts one edge later so cyc and stb drop for a cycle
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_i <= {24'h0, d};
		do begin
			@(posedge sys_clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k == 20)
			chk(ack, 1'b1);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk({24'h0, q & m}, {24'h0, e});
	endtask

	task automatic ctl(input logic [7:0] d);
		bus(1'b1, wtu_pkg::OFS_CTRL, 8'h01);
		bus(1'b1, wtu_pkg::OFS_CTRL, d);
	endtask

	// rst=1 waits for a reset pulse, rst=0 for the watchdog interrupt
	task automatic wait_for(input bit rst);
		int r0;
		r0 = rst_cnt;
		n = 0;
		while (n < 12000 && (rst ? (rst_cnt == r0) : (wint !== 1'b1))) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		int r;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(wtu_pkg::OFS_CTRL, 8'hff, 8'h10);
		rd(wtu_pkg::OFS_IRQ_STAT, 8'hff, 8'h00);
		rd(4'h2, 8'hff, 8'h00);
		bus(1'b1, wtu_pkg::OFS_IRQ_EN, 8'h03);
		// locked write with unlock clear is dropped and flagged
		bus(1'b1, wtu_pkg::OFS_CTRL, 8'h1a);
		rd(wtu_pkg::OFS_CTRL, 8'hff, 8'h10);
		rd(wtu_pkg::OFS_IRQ_STAT, 8'hff, 8'h02);
		chk(irq, 1'b1);
		bus(1'b1, wtu_pkg::OFS_IRQ_CLR, 8'h02);
		rd(wtu_pkg::OFS_IRQ_STAT, 8'hff, 8'h00);
		// an intervening read uses up the unlock
		bus(1'b1, wtu_pkg::OFS_CTRL, 8'h01);
		rd(wtu_pkg::OFS_IRQ_STAT, 8'hff, 8'h00);
		bus(1'b1, wtu_pkg::OFS_CTRL, 8'h0b);
		rd(wtu_pkg::OFS_CTRL, 8'hfe, 8'h10);
		// interrupt mode, shortest period, re-armed in time three times
		r = rst_cnt;
		ctl(8'h0b);
		repeat (3) begin
			repeat (3000) @(posedge sys_clk);
			chk(wint, 1'b0);
			ctl(8'h0b);
		end
		wait_for(1'b0);
		chk(n >= 5100 && n <= 5160, 1'b1);
		chk(wint, 1'b1);
		chk(rst_cnt, r);
		rd(wtu_pkg::OFS_CTRL, 8'hfe, 8'h0e);
		rd(wtu_pkg::OFS_IRQ_STAT, 8'hff, 8'h01);
		chk(irq, 1'b1);
		ctl(8'h09);
		repeat (2) @(posedge sys_clk);
		chk(wint, 1'b0);
		rd(wtu_pkg::OFS_CTRL, 8'hfe, 8'h08);
		bus(1'b1, wtu_pkg::OFS_IRQ_CLR, 8'h01);
		// reset mode at the doubled period: pulse, arm dropped, flag survives
		ctl(8'h13);
		wait_for(1'b1);
		chk(n >= 10220 && n <= 10260, 1'b1);
		rd(wtu_pkg::OFS_CTRL, 8'hfe, 8'h14);
		// immediate code resets at once even in interrupt mode
		ctl(8'h8b);
		wait_for(1'b1);
		chk(n <= 8, 1'b1);
		rd(wtu_pkg::OFS_CTRL, 8'hfe, 8'h8c);
		// reserved code never times out
		r = rst_cnt;
		ctl(8'h9b);
		repeat (200) @(posedge sys_clk);
		chk(rst_cnt, r);
		// supply monitor and software both drop arm
		ctl(8'h7b);
		repeat (30) @(posedge sys_clk);
		chk(wint, 1'b0);
		smi <= 1'b1;
		@(posedge sys_clk);
		smi <= 1'b0;
		rd(wtu_pkg::OFS_CTRL, 8'h02, 8'h00);
		ctl(8'h7b);
		rd(wtu_pkg::OFS_CTRL, 8'h02, 8'h02);
		ctl(8'h79);
		rd(wtu_pkg::OFS_CTRL, 8'h02, 8'h00);
		// external reset clears the flag, so trip it first
		ctl(8'h8b);
		wait_for(1'b1);
		rd(wtu_pkg::OFS_CTRL, 8'h04, 8'h04);
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(wtu_pkg::OFS_CTRL, 8'hff, 8'h10);
		end_of_test();
	end
endmodule // test_watchdog_timeout_unit
